// ---- hbfp_core.sv ----
// Triple half-bridge fault protection and gate control
// Operation
// [RULE1] Each half-bridge switch controlled independently
// [RULE2] Both sides requested: flag, force channel off
// [RULE3] Shoot-through flag holds, blocks channel till clear
// [RULE4] Sustained overcurrent latches switch off, flags
// [RULE5] Overcurrent latch released only by clear
// [RULE6] Delay select: 0 long, 1 short
// [RULE7] Timer starts on overcurrent comparator
// [RULE8] Delay fixed at timer start
// [RULE9] No turn-on during thermal shutdown
// [RULE10] Underload watched only on on-switches
// [RULE11] Persistent underload sets underload flag
// [RULE12] Shutdown enable latches offending switch off
// [RULE13] One shared underload timer for all
// [RULE14] Timer restarts when all underloads vanish
// [RULE15] Underload flag and latch cleared by clear
// [RULE16] Word bits 6..1 are switch pairs
// [RULE17] All switches off after reset
// [RULE18] Clear and requests applied together
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "hbfp_defines.svh"
module hbfp_core
    import hbfp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [5:0] oc_cmp_i,
    input wire logic [5:0] ul_cmp_i,
    input wire logic thermal_shutdown_i,
    output logic [15:0] rdata_o,
    output logic [5:0] gate_en_o,
    output logic irq_o
);
    logic [5:0] req_reg;
    logic overcurrent_delay_select_reg;
    logic underload_shutdown_enable_reg;
    logic [2:0] shoot_through_flag_reg;
    logic overcurrent_fault_flag_reg;
    logic underload_fault_flag_reg;
    logic [5:0] oc_latch_reg;
    logic [5:0] ul_latch_reg;
    logic [`HBFP_TMR_W-1:0] ul_cnt_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_en_reg;
    logic [5:0] oc_trip;
    logic [5:0] ul_active;
    logic ul_expire;
    logic cmd_wr;
    logic clr;
    logic [2:0] shoot_new;
    logic [5:0] allowed;
    logic [15:0] status_word;

    assign cmd_wr = wr_i && (addr_i == `HBFP_ADDR_CMD);
    assign clr = cmd_wr && wdata_i[`HBFP_BIT_CLEAR];

    // Per-switch overcurrent timers
    genvar g;
    generate
        for (g = 0; g < 6; g++)
        begin : g_oc
            hbfp_oc_timer u_oc (
                .clk_sys_i(clk_sys_i),
                .reset_n_i(reset_n_i),
                .oc_cmp_i(oc_cmp_i[g] && gate_en_o[g]),
                .short_sel_i(overcurrent_delay_select_reg),
                .trip_o(oc_trip[g])
            );
        end
    endgenerate

    // Shoot-through detection on a new command
    always_comb
    begin
        for (int c = 0; c < 3; c++)
            shoot_new[c] = cmd_wr && wdata_i[2*c+1] && wdata_i[2*c+2]; // [RULE2]
    end

    // Command register: requests and options
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            req_reg <= 6'h00; // [RULE17]
            overcurrent_delay_select_reg <= 1'b0;
            underload_shutdown_enable_reg <= 1'b0;
        end
        else if (cmd_wr)
        begin
            req_reg <= wdata_i[`HBFP_BIT_SW_HI:`HBFP_BIT_SW_LO]; // [RULE16] [RULE18]
            overcurrent_delay_select_reg <= wdata_i[`HBFP_BIT_OC];
            underload_shutdown_enable_reg <= wdata_i[`HBFP_BIT_UL];
        end
    end

    // Shoot-through flags per channel, set beats clear
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            shoot_through_flag_reg <= 3'h0;
        else
            shoot_through_flag_reg <= (clr ? 3'h0 : shoot_through_flag_reg) | shoot_new; // [RULE3]
    end

    // Overcurrent latches and flag
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            oc_latch_reg <= 6'h00;
            overcurrent_fault_flag_reg <= 1'b0;
        end
        else
        begin
            oc_latch_reg <= (clr ? 6'h00 : oc_latch_reg) | oc_trip; // [RULE4] [RULE5]
            overcurrent_fault_flag_reg <= (clr ? 1'b0 : overcurrent_fault_flag_reg) | (|oc_trip);
        end
    end

    // Underload detection on switched-on drivers
    assign ul_active = ul_cmp_i & gate_en_o; // [RULE10]
    assign ul_expire = (|ul_active) &&
        (ul_cnt_reg >= `HBFP_TMR_W'(`HBFP_UL_DELAY_CYC)); // [RULE11]

    // Shared underload timer
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            ul_cnt_reg <= '0;
        else if (!(|ul_active))
            ul_cnt_reg <= '0; // [RULE14]
        else if (!ul_expire)
            ul_cnt_reg <= ul_cnt_reg + `HBFP_TMR_W'(1); // [RULE13]
    end

    // Underload flag and latches
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            underload_fault_flag_reg <= 1'b0;
            ul_latch_reg <= 6'h00;
        end
        else
        begin
            underload_fault_flag_reg <= (clr ? 1'b0 : underload_fault_flag_reg) | ul_expire; // [RULE15]
            ul_latch_reg <= (clr ? 6'h00 : ul_latch_reg) |
                ((ul_expire && underload_shutdown_enable_reg) ? ul_active : 6'h00); // [RULE12]
        end
    end

    // Gate permission per switch
    always_comb
    begin
        for (int s = 0; s < 6; s++)
            allowed[s] = !shoot_through_flag_reg[s/2] && !oc_latch_reg[s] &&
                !ul_latch_reg[s]; // [RULE1] [RULE3]
    end

    // Gate enables; hold off on thermal shutdown
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            gate_en_o <= 6'h00; // [RULE17]
        else
            gate_en_o <= thermal_shutdown_i ? 6'h00 : (req_reg & allowed); // [RULE9]
    end

    // Interrupt status: shoot, overcurrent, underload
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            irq_stat_reg <= 3'h0;
        else
            irq_stat_reg <= ((wr_i && addr_i == `HBFP_ADDR_IRQ_CLR) ?
                irq_stat_reg & ~wdata_i[2:0] : irq_stat_reg) |
                {ul_expire, |oc_trip, |shoot_new};
    end

    // Interrupt enable register
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            irq_en_reg <= 3'h0;
        else if (wr_i && addr_i == `HBFP_ADDR_IRQ_EN)
            irq_en_reg <= wdata_i[2:0];
    end

    // Interrupt output
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(irq_stat_reg & irq_en_reg);
    end

    // Status word view
    always_comb
    begin
        status_word = 16'h0000;
        status_word[`HBFP_BIT_SW_HI:`HBFP_BIT_SW_LO] = gate_en_o; // [RULE16]
        status_word[`HBFP_BIT_SHOOT] = |shoot_through_flag_reg;
        status_word[`HBFP_BIT_OC] = overcurrent_fault_flag_reg;
        status_word[`HBFP_BIT_UL] = underload_fault_flag_reg;
    end

    // Read data one cycle after strobe
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            rdata_o <= 16'h0000;
        else if (rd_i)
        begin
            case (addr_i)
                `HBFP_ADDR_CMD: rdata_o <= {1'b0, underload_shutdown_enable_reg,
                    overcurrent_delay_select_reg, 6'h00, req_reg, 1'b0};
                `HBFP_ADDR_STATUS: rdata_o <= status_word;
                `HBFP_ADDR_IRQ_EN: rdata_o <= {13'h0000, irq_en_reg};
                default: rdata_o <= {13'h0000, irq_stat_reg};
            endcase
        end
        else
            rdata_o <= 16'h0000;
    end
endmodule
`default_nettype wire

// ---- hbfp_core_bench.sv ----
// Self-checking bench for the bridge guard core
`timescale 1ns/100ps
`default_nettype none
module hbfp_core_bench;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [1:0] addr_i = 2'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic rd_q = 1'b0;
    logic thermal_shutdown_i = 1'b0;
    logic [5:0] oc_load = 6'h00;
    logic [5:0] ul_load = 6'h00;
    logic [5:0] oc_cmp_i, ul_cmp_i, gate_en_o;
    logic [15:0] rdata_o;
    logic irq_o;
    logic [31:0] seed = 32'h0000_0B3E;
    logic [31:0] e;
    logic [31:0] exp_q[$];
    int n_errors = 0;
    int comparisons = 0;
    // Clock
    initial
    begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    hbfp_core DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .oc_cmp_i(oc_cmp_i), .ul_cmp_i(ul_cmp_i), .rdata_o(rdata_o),
        .thermal_shutdown_i(thermal_shutdown_i), .gate_en_o(gate_en_o),
        .irq_o(irq_o));
    hbfp_loads LOADS (.clk_sys_i(clk_sys_i), .gate_en_i(gate_en_o),
        .oc_load_i(oc_load), .ul_load_i(ul_load), .oc_cmp_o(oc_cmp_i),
        .ul_cmp_o(ul_cmp_i));
    task automatic stop_test();
        if (n_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
        comparisons++;
        if (s !== x)
        begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", nm, x, s);
        end
    endtask
    task automatic gate(input logic [5:0] x);
        chk("gate", {10'h000, gate_en_o}, {10'h000, x});
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    // Unused bits 11..7 carry xorshift noise
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        addr_i <= a;
        wdata_i <= d | {4'h0, seed[4:0], 7'h00};
        wr_i <= 1'b1;
        step(1);
        wr_i <= 1'b0;
        step(1);
    endtask
    task automatic rd(input logic [15:0] m, input logic [15:0] x);
        exp_q.push_back({m, x});
        addr_i <= 2'h1;
        rd_i <= 1'b1;
        step(1);
        rd_i <= 1'b0;
        step(1);
    endtask
    // Read data stands one cycle after the strobe
    always @(posedge clk_sys_i)
    begin
        rd_q <= rd_i;
        if (rd_q)
        begin
            e = exp_q.pop_front();
            chk("status", rdata_o & e[31:16], e[15:0]);
        end
    end
    initial
    begin
        step(30000);
        n_errors++;
        stop_test();
    end
    initial
    begin
        step(5);
        reset_n_i <= 1'b1;
        gate(6'h00);
        wr(2'h2, 16'h0007);
        wr(2'h0, 16'h0004);
        step(1);
        gate(6'h02);
        rd(16'h007E, 16'h0004);
        wr(2'h0, 16'h0016);
        step(1);
        gate(6'h08);
        rd(16'h107E, 16'h1010);
        chk("irq", {15'h0000, irq_o}, 16'h0001);
        wr(2'h0, 16'h0004);
        step(1);
        gate(6'h00);
        wr(2'h0, 16'h0005);
        step(1);
        gate(6'h02);
        rd(16'h1000, 16'h0000);
        wr(2'h2, 16'h0000);
        step(1);
        chk("irq", {15'h0000, irq_o}, 16'h0000);
        wr(2'h3, 16'h0007);
        wr(2'h2, 16'h0007);
        step(1);
        chk("irq", {15'h0000, irq_o}, 16'h0000);
        thermal_shutdown_i <= 1'b1;
        wr(2'h0, 16'h0001);
        wr(2'h0, 16'h0005);
        step(1);
        gate(6'h00);
        thermal_shutdown_i <= 1'b0;
        for (int i = 0; i < 2; i++)
        begin
            wr(2'h0, i ? 16'h2005 : 16'h0005);
            oc_load <= 6'h02;
            // Let the timer start before the delay select flips
            step(3);
            wr(2'h0, i ? 16'h0004 : 16'h2004);
            step(i ? 230 : 1980);
            gate(6'h02);
            step(40);
            gate(6'h00);
            oc_load <= 6'h00;
            rd(16'h2000, 16'h2000);
            wr(2'h0, 16'h0004);
            step(1);
            gate(6'h00);
        end
        wr(2'h0, 16'h4015);
        ul_load <= 6'h02;
        step(1500);
        ul_load <= 6'h00;
        step(5);
        ul_load <= 6'h02;
        step(1500);
        gate(6'h0A);
        ul_load <= 6'h0A;
        step(520);
        gate(6'h00);
        rd(16'h4000, 16'h4000);
        wr(2'h0, 16'h0015);
        step(2020);
        gate(6'h0A);
        rd(16'h4000, 16'h4000);
        ul_load <= 6'h00;
        // Underload must be gone first, or a fresh set beats the clear
        step(2);
        wr(2'h0, 16'h0001);
        rd(16'h4000, 16'h0000);
        stop_test();
    end
endmodule
bind hbfp_core hbfp_monitor MON (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .oc_cmp_i(oc_cmp_i), .ul_cmp_i(ul_cmp_i), .rdata_o(rdata_o),
    .thermal_shutdown_i(thermal_shutdown_i), .gate_en_o(gate_en_o),
    .irq_o(irq_o));
`default_nettype wire

// ---- hbfp_defines.svh ----
// Offsets, field positions and timing counts for the bridge guard
`ifndef HBFP_DEFINES_SVH
`define HBFP_DEFINES_SVH

`define HBFP_CLK_MHZ 10
`define HBFP_OC_LONG_US 200
`define HBFP_OC_SHORT_US 25
`define HBFP_OC_LONG_CYC (`HBFP_OC_LONG_US * `HBFP_CLK_MHZ)
`define HBFP_OC_SHORT_CYC (`HBFP_OC_SHORT_US * `HBFP_CLK_MHZ)
`define HBFP_UL_DELAY_US 200
`define HBFP_UL_DELAY_CYC (`HBFP_UL_DELAY_US * `HBFP_CLK_MHZ)
`define HBFP_TMR_W 12

`define HBFP_BIT_CLEAR 0
`define HBFP_BIT_SW_LO 1
`define HBFP_BIT_SW_HI 6
`define HBFP_BIT_SHOOT 12
`define HBFP_BIT_OC 13
`define HBFP_BIT_UL 14

`define HBFP_ADDR_CMD 2'h0
`define HBFP_ADDR_STATUS 2'h1
`define HBFP_ADDR_IRQ_EN 2'h2
`define HBFP_ADDR_IRQ_CLR 2'h3

`endif

// ---- hbfp_loads.sv ----
// Load comparator model facing the bridge guard core
`timescale 1ns/100ps
`default_nettype none
module hbfp_loads (
    input wire logic clk_sys_i,
    input wire logic [5:0] gate_en_i,
    input wire logic [5:0] oc_load_i,
    input wire logic [5:0] ul_load_i,
    output logic [5:0] oc_cmp_o,
    output logic [5:0] ul_cmp_o
);
    // Comparators only see current through a switch that is on
    always_ff @(posedge clk_sys_i)
    begin
        oc_cmp_o <= gate_en_i & oc_load_i;
        ul_cmp_o <= gate_en_i & ul_load_i;
    end
endmodule
`default_nettype wire

// ---- hbfp_monitor.sv ----
// Port-level assertions for the bridge guard core
`timescale 1ns/100ps
`default_nettype none
`include "hbfp_defines.svh"
module hbfp_monitor (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [5:0] oc_cmp_i,
    input wire logic [5:0] ul_cmp_i,
    input wire logic thermal_shutdown_i,
    input wire logic [15:0] rdata_o,
    input wire logic [5:0] gate_en_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);
    logic [5:0] req_w;
    int oc_cnt;
    // Request field of the write bus
    assign req_w = wdata_i[6:1];
    // Run length of overcurrent on switch 1 while it is on
    always_ff @(posedge clk_sys_i)
        oc_cnt <= (!reset_n_i || !(oc_cmp_i[1] && gate_en_o[1])) ? 0 : oc_cnt + 1;
    sequence cmd_wr;
        wr_i && addr_i == 2'h0 ##1 !(wr_i && addr_i == 2'h0);
    endsequence
    cmd_gate_a: assert property (cmd_wr |=>
        (gate_en_o & ~$past(req_w, 2)) == 6'h00) else $error("gate unasked");
    no_overlap_a: assert property (
        !(|(gate_en_o & (gate_en_o >> 1) & 6'h15))) else $error("overlap");
    shoot_off_a: assert property (wr_i && addr_i == 2'h0 &&
        wdata_i[2:1] == 2'b11 |-> ##2 (gate_en_o[1:0] == 2'b00) [*3])
        else $error("shoot not off");
    heat_block_a: assert property (thermal_shutdown_i [*3] |->
        (gate_en_o & ~$past(gate_en_o)) == 6'h00) else $error("hot turn on");
    oc_bound_a: assert property (
        oc_cnt <= `HBFP_OC_LONG_CYC + 4) else $error("no oc trip");
    read_idle_a: assert property (
        !rd_i |=> rdata_o == 16'h0000) else $error("rdata not idle");
    irq_mask_a: assert property (wr_i && addr_i == 2'h2 && wdata_i[2:0] == 3'h0
        ##1 !(wr_i && addr_i == 2'h2) |=> !irq_o) else $error("irq unmasked");
    reset_off_a: assert property (disable iff (1'b0)
        !reset_n_i |=> gate_en_o == 6'h00 && !irq_o) else $error("reset on");
endmodule
`default_nettype wire

// ---- hbfp_oc_timer.sv ----
// Per-switch overcurrent shutdown delay timer
`timescale 1ns/100ps
`default_nettype none
`include "hbfp_defines.svh"
module hbfp_oc_timer
    import hbfp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic oc_cmp_i,
    input wire logic short_sel_i,
    output logic trip_o
);
    hbfp_oc_state_t state_reg;
    logic [`HBFP_TMR_W-1:0] cnt_reg;
    logic [`HBFP_TMR_W-1:0] limit_reg;

    // Delay latched at start, held for the whole count
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= HBFP_OC_IDLE;
            cnt_reg <= '0;
            limit_reg <= '0;
            trip_o <= 1'b0;
        end
        else
        begin
            trip_o <= 1'b0;
            case (state_reg)
                HBFP_OC_IDLE:
                begin
                    cnt_reg <= '0;
                    if (oc_cmp_i) // [RULE7]
                    begin
                        state_reg <= HBFP_OC_COUNT;
                        cnt_reg <= `HBFP_TMR_W'(1);
                        limit_reg <= short_sel_i ? // [RULE6] [RULE8]
                            `HBFP_TMR_W'(`HBFP_OC_SHORT_CYC) :
                            `HBFP_TMR_W'(`HBFP_OC_LONG_CYC);
                    end
                end
                HBFP_OC_COUNT:
                begin
                    if (!oc_cmp_i)
                        state_reg <= HBFP_OC_IDLE;
                    else if (cnt_reg >= limit_reg) // [RULE4]
                    begin
                        trip_o <= 1'b1;
                        state_reg <= HBFP_OC_TRIP;
                    end
                    else
                        cnt_reg <= cnt_reg + `HBFP_TMR_W'(1);
                end
                HBFP_OC_TRIP:
                begin
                    if (!oc_cmp_i)
                        state_reg <= HBFP_OC_IDLE;
                end
                default:
                    state_reg <= HBFP_OC_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- hbfp_pkg.sv ----
// Types shared by the bridge guard files
`default_nettype none
package hbfp_pkg;
    typedef enum logic [1:0] {HBFP_OC_IDLE, HBFP_OC_COUNT, HBFP_OC_TRIP} hbfp_oc_state_t;
endpackage
`default_nettype wire
